// >>> pkg/fspc_pkg.sv
// Purpose: shared constants for the flash self-program controller
// Assumes: one 25 MHz clock, one instruction cycle per clock
// Notes:   register selects and control bit positions are fixed here

package fspc_pkg;

   // ==========================================================
   // widths and latch array
   localparam int unsigned DATA_W    = 14;
   localparam int unsigned ADDR_W    = 15;
   localparam int unsigned LATCH_N   = 32;
   localparam int unsigned IDX_W     = 5;
   localparam logic [13:0] BLANK_WORD = 14'h3FFF;

   // ==========================================================
   // register selects on the special-register port
   localparam logic [2:0] SEL_ADDR_LO = 3'h0;
   localparam logic [2:0] SEL_ADDR_HI = 3'h1;
   localparam logic [2:0] SEL_DATA_LO = 3'h2;
   localparam logic [2:0] SEL_DATA_HI = 3'h3;
   localparam logic [2:0] SEL_CTRL    = 3'h4;
   localparam logic [2:0] SEL_KEY     = 3'h5;

   // ==========================================================
   // control register bit positions and reset value
   localparam int unsigned CTL_RD    = 0;
   localparam int unsigned CTL_WR    = 1;
   localparam int unsigned CTL_GATE  = 2;
   localparam int unsigned CTL_ABORT = 3;
   localparam int unsigned CTL_ERASE = 4;
   localparam int unsigned CTL_LATCH = 5;
   localparam int unsigned CTL_CFG   = 6;
   localparam logic [7:0]  CTL_RESET = 8'h00;

   // ==========================================================
   // unlock keys
   localparam logic [7:0] KEY_FIRST  = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'hAA;

   // ==========================================================
   // self-program guard settings and region bounds
   localparam logic [1:0]  GUARD_ALL  = 2'h0;
   localparam logic [1:0]  GUARD_HALF = 2'h1;
   localparam logic [1:0]  GUARD_BOOT = 2'h2;
   localparam logic [14:0] GUARD_BOOT_END = 15'h0200;
   localparam logic [14:0] GUARD_HALF_END = 15'h4000;

   // ==========================================================
   // row erase / row program duration
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned ROW_OP_TIME_NS = 2000000;
   localparam int unsigned ROW_OP_CYCLES_DFLT =
      ROW_OP_TIME_NS / CLK_PERIOD_NS;

   // ==========================================================
   // sequencer and unlock states
   typedef enum logic [6:0]
   {
      ST_IDLE     = 7'h01,
      ST_RD_WAIT  = 7'h02,
      ST_RD_STEAL = 7'h04,
      ST_NOP1     = 7'h08,
      ST_NOP2     = 7'h10,
      ST_STREAM   = 7'h20,
      ST_TIMER    = 7'h40
   } fspc_state_t;

   typedef enum logic [2:0]
   {
      KEY_IDLE  = 3'h1,
      KEY_HALF  = 3'h2,
      KEY_ARMED = 3'h4
   } fspc_key_t;

endpackage

// >>> pkg/fspc_latch_if.sv
// Purpose: carrier between the sequencer and the write latch store
// Assumes: single clock domain
// Notes:   read data is registered inside the store

`timescale 1ns/1ps

interface fspc_latch_if;
   logic        wr_en;
   logic [4:0]  wr_idx;
   logic [13:0] wr_data;
   logic [4:0]  rd_idx;
   logic [13:0] rd_data;
   logic        clear;

   modport ctl (output wr_en, wr_idx, wr_data, rd_idx, clear,
                input rd_data);
   modport mem (input wr_en, wr_idx, wr_data, rd_idx, clear,
                output rd_data);
endinterface

// >>> rtl/fspc_latch_mem.sv
// Purpose: 32 word-wide write latches for row programming
// Assumes: clear and write never collide in one cycle
// Notes:   read data one cycle after the index

`timescale 1ns/1ps

module fspc_latch_mem
   import fspc_pkg::*;
(
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   fspc_latch_if.mem   lat
);

   logic [13:0] word [LATCH_N];

   // ==========================================================
   // latch store: blank after reset and after each row operation
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         for (int i = 0; i < LATCH_N; i++)
            word[i] <= BLANK_WORD;
      end
      else if (lat.clear)
      begin
         for (int i = 0; i < LATCH_N; i++)
            word[i] <= BLANK_WORD;
      end
      else if (lat.wr_en)
         word[lat.wr_idx] <= lat.wr_data;
   end

   // registered read port
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         lat.rd_data <= BLANK_WORD;
      else
         lat.rd_data <= word[lat.rd_idx];
   end

endmodule

// >>> rtl/fspc_top.sv
// Purpose: flash self-program controller (read, row erase, program)
// Assumes: one instruction per clock; core honours squash and stall
// Notes:   array read data is sampled in the cycle array_rd_o is high
//
// Overview of operation
// - data pair holds 14-bit word, address pair holds 15-bit word address
// - erase and program durations come from an internal cycle timer
// - readout lock low blocks external reads and writes, not self ops
// - only an external bulk erase releases the readout lock
// - guard setting refuses self erase/write in its region only
// - high address byte holds upper bits, low byte the lower eight
// - read-go and program-go set by software, cleared by hardware only
// - erase or program needs the enable gate, cleared at power-up
// - reset during a row operation sets the abort flag
// - unlock-key register is write-only and reads as zero
// - erase works on 32-word rows; 32 write latches exist
// - latches are hidden and filled only through the data pair
// - second cycle after read-go is stolen; data ready next cycle
// - data pair holds the read word until next read or write
// - unlock order is 55h, AAh, program-go, two no-operations
// - erase, latch load and row writes need a complete unlock
// - setting program-go forces the next two slots to no-ops
// - row erase or program stalls the core until it ends
// - latch load does not stall after the two forced no-ops
// - latch-only mode loads one latch; else whole row is written
// - erase-select with gate turns the operation into row erase
// - every row write or erase returns all latches to 3FFFh
// - upper ten address bits pick row, lower five pick the latch

`timescale 1ns/1ps

module fspc_top
   import fspc_pkg::*;
#(
   parameter int unsigned ROW_OP_CYCLES = ROW_OP_CYCLES_DFLT
)
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        por_n_i,
   input  wire logic [2:0]  sfr_sel_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  sfr_rdata_o,
   output logic             squash_o,
   output logic             stall_o,
   input  wire logic        readout_lock_n_i,
   input  wire logic [1:0]  self_program_guard_i,
   input  wire logic        ext_rd_i,
   input  wire logic        ext_wr_i,
   input  wire logic        ext_bulk_erase_i,
   output logic             ext_rd_en_o,
   output logic             ext_wr_en_o,
   output logic             ext_bulk_erase_o,
   output logic      [14:0] array_addr_o,
   output logic             array_rd_o,
   input  wire logic [13:0] array_rdata_i,
   output logic             array_wr_o,
   output logic      [13:0] array_wdata_o,
   output logic             array_erase_o,
   output logic             array_cfg_o
);

   // ==========================================================
   // reset release: two flops each; sys reset joins both
   logic rst_meta, rst_q, por_meta, por_q, sys_rst_n;

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         {rst_q, rst_meta} <= 2'h0;
      else
         {rst_q, rst_meta} <= {rst_meta, 1'b1};
   end

   always_ff @(posedge ref_clk_i or negedge por_n_i)
   begin
      if (!por_n_i)
         {por_q, por_meta} <= 2'h0;
      else
         {por_q, por_meta} <= {por_meta, 1'b1};
   end

   assign sys_rst_n = rst_q & por_q;

   // ==========================================================
   // registers and decode
   fspc_state_t state, next_state;
   fspc_key_t   key_state;
   logic [14:0] addr;
   logic [13:0] data;
   logic        rd_go, wr_go, gate, erase_sel, latch_only, cfg_sel;
   logic        abort_flag, inflight;
   logic [5:0]  str_cnt;
   logic [15:0] tmr;
   logic        idle, wr_ctl, rd_start, wr_req, wr_ok, guard_hit;
   fspc_latch_if lat ();

   assign idle     = (state == ST_IDLE);
   assign wr_ctl   = sfr_wr_i && (sfr_sel_i == SEL_CTRL);
   assign rd_start = wr_ctl && idle && sfr_wdata_i[CTL_RD];
   assign wr_req   = wr_ctl && idle && !sfr_wdata_i[CTL_RD] &&
                     sfr_wdata_i[CTL_WR];

   // guard region test on a word address
   function automatic logic guarded(input logic [1:0] g,
                                    input logic [14:0] a);
      logic hit;
      hit = 1'b0;
      case (g)
         GUARD_ALL:  hit = 1'b1;
         GUARD_HALF: hit = (a < GUARD_HALF_END);
         GUARD_BOOT: hit = (a < GUARD_BOOT_END);
         default:    hit = 1'b0;
      endcase
      return hit;
   endfunction

   assign guard_hit = !cfg_sel && guarded(self_program_guard_i, addr) &&
                      (erase_sel || !latch_only);
   assign wr_ok = wr_req && (key_state == KEY_ARMED) && gate && !guard_hit;

   // ==========================================================
   // external access gating
   assign ext_rd_en_o = ext_rd_i && readout_lock_n_i;
   assign ext_wr_en_o = ext_wr_i && readout_lock_n_i;
   // bulk erase always allowed, it clears the lock
   assign ext_bulk_erase_o = ext_bulk_erase_i;

   // ==========================================================
   // address pair; frozen while an operation runs
   // split address pair
   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
         addr <= 15'h0000;
      else if (sfr_wr_i && idle && sfr_sel_i == SEL_ADDR_LO)
         addr[7:0] <= sfr_wdata_i;
      else if (sfr_wr_i && idle && sfr_sel_i == SEL_ADDR_HI)
         addr[14:8] <= sfr_wdata_i[6:0];
   end

   // data pair: read capture or software write only
   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
         data <= 14'h0000;
      else if (state == ST_RD_STEAL)
         data <= array_rdata_i;
      else if (sfr_wr_i && sfr_sel_i == SEL_DATA_LO)
         data[7:0] <= sfr_wdata_i;
      else if (sfr_wr_i && sfr_sel_i == SEL_DATA_HI)
         data[13:8] <= sfr_wdata_i[5:0];
   end

   // ==========================================================
   // control bits; mode bits only change while idle
   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         {cfg_sel, latch_only, erase_sel, gate} <= 4'h0;
      end
      else if (wr_ctl && idle)
      begin
         gate       <= sfr_wdata_i[CTL_GATE];
         erase_sel  <= sfr_wdata_i[CTL_ERASE];
         latch_only <= sfr_wdata_i[CTL_LATCH];
         cfg_sel    <= sfr_wdata_i[CTL_CFG];
      end
   end

   // go bits: set by software, cleared by hardware
   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
         {wr_go, rd_go} <= 2'h0;
      else
      begin
         if (rd_start)
            rd_go <= 1'b1;
         else if (state == ST_RD_STEAL)
            rd_go <= 1'b0;
         if (wr_ok)
            wr_go <= 1'b1;
         else if (next_state == ST_IDLE)
            wr_go <= 1'b0;
      end
   end

   // unlock tracker; any other write disarms
   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
         key_state <= KEY_IDLE;
      else if (sfr_wr_i && sfr_sel_i == SEL_KEY &&
               sfr_wdata_i == KEY_FIRST)
         key_state <= KEY_HALF;
      else if (sfr_wr_i && sfr_sel_i == SEL_KEY &&
               sfr_wdata_i == KEY_SECOND && key_state == KEY_HALF)
         key_state <= KEY_ARMED;
      else if (sfr_wr_i)
         key_state <= KEY_IDLE;
   end

   // ==========================================================
   // abort flag survives core reset; set beats software clear
   always_ff @(posedge ref_clk_i or negedge por_q)
   begin
      if (!por_q)
      begin
         inflight   <= 1'b0;
         abort_flag <= 1'b0;
      end
      else if (!rst_q)
      begin
         inflight   <= 1'b0;
         abort_flag <= abort_flag | inflight;
      end
      else
      begin
         inflight <= stall_o;
         if (wr_ctl && !sfr_wdata_i[CTL_ABORT])
            abort_flag <= 1'b0;
      end
   end

   // key register reads zero; latches have no read path
   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
         sfr_rdata_o <= 8'h00;
      else if (sfr_rd_i)
      begin
         case (sfr_sel_i)
            SEL_ADDR_LO: sfr_rdata_o <= addr[7:0];
            SEL_ADDR_HI: sfr_rdata_o <= {1'b0, addr[14:8]};
            SEL_DATA_LO: sfr_rdata_o <= data[7:0];
            SEL_DATA_HI: sfr_rdata_o <= {2'h0, data[13:8]};
            SEL_CTRL:    sfr_rdata_o <= {1'b0, cfg_sel, latch_only,
                                         erase_sel, abort_flag, gate,
                                         wr_go, rd_go};
            default:     sfr_rdata_o <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // sequencer next state
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
         begin
            if (rd_start)
               next_state = ST_RD_WAIT;
            else if (wr_ok)
               next_state = ST_NOP1;
         end
         ST_RD_WAIT:  next_state = ST_RD_STEAL;
         ST_RD_STEAL: next_state = ST_IDLE;
         ST_NOP1:     next_state = ST_NOP2;
         // latch load returns at once; erase skips stream
         ST_NOP2:
         begin
            if (erase_sel)
               next_state = ST_TIMER;
            else if (latch_only)
               next_state = ST_IDLE;
            else
               next_state = ST_STREAM;
         end
         ST_STREAM:
         begin
            if (str_cnt == 6'(LATCH_N))
               next_state = ST_TIMER;
         end
         ST_TIMER:
         begin
            if (tmr == 16'h0000)
               next_state = ST_IDLE;
         end
         default:     next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   // internal duration timer and stream counter
   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         tmr     <= 16'h0000;
         str_cnt <= 6'h00;
      end
      else
      begin
         if (next_state == ST_TIMER && state != ST_TIMER)
            tmr <= 16'(ROW_OP_CYCLES - 1);
         else if (state == ST_TIMER)
            tmr <= tmr - 16'h0001;
         str_cnt <= (state == ST_STREAM) ? str_cnt + 6'h01 : 6'h00;
      end
   end

   // steal slot; two forced no-ops; stall
   assign squash_o = (state == ST_RD_STEAL) || (state == ST_NOP1) ||
                     (state == ST_NOP2);
   assign stall_o  = (state == ST_STREAM) || (state == ST_TIMER);

   // ==========================================================
   // latch store: load addressed latch; blank after row op
   assign lat.wr_en   = wr_ok && !erase_sel;
   // low five bits pick the latch
   assign lat.wr_idx  = addr[IDX_W-1:0];
   assign lat.wr_data = data;
   assign lat.rd_idx  = str_cnt[IDX_W-1:0];
   assign lat.clear   = (state == ST_TIMER) && (tmr == 16'h0000);

   fspc_latch_mem u_latch (
      .clk_i   (ref_clk_i),
      .rst_n_i (sys_rst_n),
      .lat     (lat)
   );

   // array strobes; row from upper ten bits
   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         array_addr_o  <= 15'h0000;
         array_rd_o    <= 1'b0;
         array_wr_o    <= 1'b0;
         array_wdata_o <= BLANK_WORD;
         array_erase_o <= 1'b0;
         array_cfg_o   <= 1'b0;
      end
      else
      begin
         array_rd_o    <= (state == ST_RD_WAIT);
         array_wr_o    <= (state == ST_STREAM) && (str_cnt != 6'h00);
         array_wdata_o <= lat.rd_data;
         array_erase_o <= (state == ST_NOP2) && erase_sel;
         array_cfg_o   <= cfg_sel;
         if (state == ST_STREAM)
            array_addr_o <= {addr[14:5], 5'(str_cnt - 6'h01)};
         else
            array_addr_o <= addr;
      end
   end

   // ==========================================================
   // checks
   logic [16:0] stall_cnt;

   always_ff @(posedge ref_clk_i or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
         stall_cnt <= 17'h0_0000;
      else
         stall_cnt <= stall_o ? stall_cnt + 17'h0_0001 : 17'h0_0000;
   end

   sequence s_read_set;
      state == ST_IDLE && rd_start;
   endsequence

   sequence s_steal;
      !squash_o ##1 (squash_o && array_rd_o) ##1 !rd_go;
   endsequence

   sequence s_go_accept;
      state == ST_IDLE && wr_ok;
   endsequence

   a_read_steal_slot: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      s_read_set |=> s_steal)
      else $error("read slot not stolen on the second cycle");

   a_data_pair_hold: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      (state != ST_RD_STEAL && !(sfr_wr_i && (sfr_sel_i == SEL_DATA_LO ||
       sfr_sel_i == SEL_DATA_HI))) |=> $stable(data))
      else $error("data pair changed without read or write");

   a_go_bits_sticky: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      (wr_go && !stall_o && !squash_o) |-> ##0 0)
      else $error("program-go left set after its operation");

   a_key_reads_zero: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      (sfr_rd_i && sfr_sel_i == SEL_KEY) |=> sfr_rdata_o == 8'h00)
      else $error("unlock-key register read non-zero");

   a_forced_nops: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      s_go_accept |=> squash_o [*2])
      else $error("program-go did not force two no-ops");

   a_refused_go: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      (wr_req && !wr_ok) |-> !lat.wr_en ##1 (!wr_go && idle))
      else $error("refused program-go had an effect");

   a_unlock_needed: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      lat.wr_en |-> (key_state == KEY_ARMED && gate))
      else $error("latch written without unlock and gate");

   a_guard_region: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      (array_erase_o || array_wr_o) |->
         (array_cfg_o || !guarded(self_program_guard_i, array_addr_o)))
      else $error("self erase or write inside guarded region");

   a_latch_no_stall: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      (s_go_accept ##0 (latch_only && !erase_sel)) |-> ##3 (idle && !stall_o))
      else $error("latch load stalled the core");

   a_stall_bounded: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      stall_o |-> stall_cnt < 17'(ROW_OP_CYCLES + LATCH_N + 1))
      else $error("row operation stall ran too long");

   a_blank_after_row: assert property (
      @(posedge ref_clk_i) disable iff (!sys_rst_n)
      $fell(stall_o) |-> $past(lat.clear))
      else $error("latches not blanked at end of row operation");

   a_abort_on_reset: assert property (
      @(posedge ref_clk_i) disable iff (!por_q)
      (!rst_q && inflight) |=> abort_flag)
      else $error("reset during row operation left abort flag clear");

endmodule

// >>> verification/fspc_flash_model.sv
// Purpose: behavioural flash array seen by the controller
// Assumes: read data is combinational on the address
// Notes:   a fixed pattern per address keeps expectations simple

`timescale 1ns/1ps

module fspc_flash_model
(
   input  wire logic [14:0] addr_i,
   output logic      [13:0] rdata_o
);
   // ==========================================================
   // array contents: address folded with a constant pattern
   assign rdata_o = addr_i[13:0] ^ 14'h1A5C;
endmodule

// >>> verification/flash_self_program_control_tb.sv
// Purpose: self-checking bench for the flash self-program controller
// Assumes: inputs change 1 ns after the rising edge
// Notes:   row timer shortened so row operations stay brief

`timescale 1ns/1ps

module flash_self_program_control_tb
   import fspc_pkg::*;
;
   localparam int ROWC = 20;
   logic        clk = 0, rst_n = 0, por_n = 0, wr = 0, rd = 0;
   logic        lock_n = 1, ex_rd = 0, ex_wr = 0, ex_be = 0;
   logic [2:0]  sel = '0;
   logic [1:0]  guard = 2'h3;
   logic [7:0]  wd = '0, rdat, rdo;
   logic        sq, st, rde, wre, bee, ard, awr, aer, acfg;
   logic [14:0] aad, ra, a;
   logic [13:0] ardat, awd, d1, d2, hit_a, hit_b;
   logic [4:0]  ia, ib;
   int num_errors = 0, n_compared = 0, cyc = 0;
   int n_sq, n_st, n_wr, n_er, n_bad;

   // ==========================================================
   // clock, design and array model
   always #20 clk = ~clk;

   fspc_top #(.ROW_OP_CYCLES(ROWC)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n),
      .por_n_i(por_n), .sfr_sel_i(sel), .sfr_wr_i(wr), .sfr_rd_i(rd),
      .sfr_wdata_i(wd), .sfr_rdata_o(rdo), .squash_o(sq), .stall_o(st),
      .readout_lock_n_i(lock_n), .self_program_guard_i(guard),
      .ext_rd_i(ex_rd), .ext_wr_i(ex_wr), .ext_bulk_erase_i(ex_be),
      .ext_rd_en_o(rde), .ext_wr_en_o(wre), .ext_bulk_erase_o(bee),
      .array_addr_o(aad), .array_rd_o(ard), .array_rdata_i(ardat),
      .array_wr_o(awr), .array_wdata_o(awd), .array_erase_o(aer),
      .array_cfg_o(acfg));

   fspc_flash_model model (.addr_i(aad), .rdata_o(ardat));

   // ==========================================================
   // monitor: counts squash, stall and array pulses; cuts hangs
   always @(posedge clk)
   begin
      cyc++;
      n_sq += sq;
      n_st += st;
      n_er += aer;
      if (ard)
         ra = aad;
      if (awr)
      begin
         n_wr++;
         if (aad[14:5] !== a[14:5])
            n_bad++;
         if (aad[4:0] == ia)
            hit_a = awd;
         else if (aad[4:0] == ib)
            hit_b = awd;
         else if (awd !== BLANK_WORD)
            n_bad++;
      end
      if (cyc == 20000)
      begin
         num_errors++;
         close_out();
      end
   end

   function automatic logic [13:0] exp_rd(input logic [14:0] x);
      return x[13:0] ^ 14'h1A5C;
   endfunction

   task automatic chk(input string nm, input logic [15:0] s, e);
      n_compared++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask

   task automatic wreg(input logic [2:0] s, input logic [7:0] d);
      @(posedge clk) #1;
      sel = s;
      wd = d;
      wr = 1;
      @(posedge clk) #1;
      wr = 0;
   endtask

   task automatic rreg(input logic [2:0] s, output logic [7:0] d);
      @(posedge clk) #1;
      sel = s;
      rd = 1;
      @(posedge clk) #1;
      rd = 0;
      @(posedge clk) #1;
      d = rdo;
   endtask

   task automatic setad(input logic [14:0] x, input logic [13:0] d);
      wreg(SEL_ADDR_LO, x[7:0]);
      wreg(SEL_ADDR_HI, {1'b0, x[14:8]});
      wreg(SEL_DATA_LO, d[7:0]);
      wreg(SEL_DATA_HI, {2'b00, d[13:8]});
   endtask

   task automatic clr();
      n_sq = 0;
      n_st = 0;
      n_wr = 0;
      n_er = 0;
      n_bad = 0;
      hit_a = '0;
   endtask

   // mode write, optional key pair, then go with the same mode bits
   task automatic go(input logic [7:0] m, input bit key, input int n);
      wreg(SEL_CTRL, m);
      if (key)
      begin
         wreg(SEL_KEY, KEY_FIRST);
         wreg(SEL_KEY, KEY_SECOND);
      end
      clr();
      wreg(SEL_CTRL, m | 8'h02);
      repeat (n) @(posedge clk);
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      void'($urandom(72));
      repeat (20) @(posedge clk);
      #1 rst_n = 1;
      por_n = 1;
      repeat (3) @(posedge clk);
      rreg(SEL_CTRL, rdat);
      chk("ctrl reset", rdat, CTL_RESET);
      rreg(SEL_KEY, rdat);
      chk("key read", rdat, 8'h00);
      $display("test reset done");
      // reads: top address first, then random ones
      for (int i = 0; i < 4; i++)
      begin
         a = (i == 0) ? 15'h7FFF : 15'($urandom);
         // address loaded, config select clear, then read-go
         setad(a, 14'($urandom));
         clr();
         wreg(SEL_CTRL, 8'h01);
         repeat (4) @(posedge clk);
         chk("read squash", 16'(n_sq), 16'd1);
         chk("read addr", ra, a);
         rreg(SEL_DATA_LO, rdat);
         chk("data lo", rdat, exp_rd(a) & 14'h00FF);
         rreg(SEL_DATA_HI, rdat);
         chk("data hi", rdat[5:0], exp_rd(a) >> 8);
         rreg(SEL_CTRL, rdat);
         chk("rd cleared", rdat[CTL_RD], 1'b0);
         chk("cfg copy", acfg, 1'b0);
      end
      $display("test read done");
      go(8'h04, 0, 8);
      chk("no key squash", 16'(n_sq), 16'd0);
      rreg(SEL_CTRL, rdat);
      chk("go dropped", rdat[CTL_WR], 1'b0);
      go(8'h00, 1, 8);
      chk("no gate squash", 16'(n_sq), 16'd0);
      $display("test refuse done");
      // one latch load, then a row write from another index
      a = 15'($urandom);
      ia = 5'($urandom);
      ib = ia + 5'd1;
      d1 = 14'($urandom);
      d2 = 14'($urandom);
      setad({a[14:5], ia}, d1);
      go(8'h24, 1, 8);
      chk("load squash", 16'(n_sq), 16'd2);
      chk("load stall", 16'(n_st), 16'd0);
      setad({a[14:5], ib}, d2);
      go(8'h04, 1, 80);
      chk("prog stall", 16'(n_st), 16'(33 + ROWC));
      chk("prog words", 16'(n_wr), 16'd32);
      chk("latch a", hit_a, d1);
      chk("latch b", hit_b, d2);
      chk("other latches", 16'(n_bad), 16'd0);
      go(8'h04, 1, 80);
      chk("latch blank", hit_a, BLANK_WORD);
      go(8'h14, 1, 40);
      chk("erase pulse", 16'(n_er), 16'd1);
      chk("erase stall", 16'(n_st), 16'(ROWC));
      #1 guard = GUARD_ALL;
      go(8'h14, 1, 40);
      chk("guarded erase", 16'(n_er + n_st), 16'd0);
      // half and boot guards: upper half allowed, low page refused
      for (int g = 1; g < 3; g++)
      begin
         #1 guard = 2'(g);
         setad({1'b1, a[13:0]}, d2);
         go(8'h14, 1, 40);
         chk("erase above", 16'(n_er), 16'd1);
         setad(15'h0100, d2);
         go(8'h14, 1, 40);
         chk("erase below", 16'(n_er + n_st), 16'd0);
      end
      #1 guard = 2'h3;
      $display("test program done");
      // core reset in mid row write leaves the abort flag
      go(8'h04, 1, 10);
      #1 rst_n = 0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1;
      repeat (4) @(posedge clk);
      rreg(SEL_CTRL, rdat);
      chk("abort flag", rdat[CTL_ABORT], 1'b1);
      for (int l = 0; l < 2; l++)
      begin
         lock_n = l[0];
         ex_rd = 1;
         ex_wr = 1;
         ex_be = 1;
         #1;
         chk("ext grant", {rde, wre}, {2{l[0]}});
         chk("bulk erase", bee, 1'b1);
      end
      $display("test lock done");
      close_out();
   end
endmodule
